// ===== include/eis_consts.svh
// Constants for the external interrupt edge-select block
`ifndef EIS_CONSTS_SVH
`define EIS_CONSTS_SVH

// Pin count: irq a, irq b, wake 0..5
`define EIS_NPINS 8
`define EIS_NWAKE 6
`define EIS_AW 8

// Register byte offsets
`define EIS_OFF_IRQ_EDGE 8'h00
`define EIS_OFF_WAKE_EDGE 8'h04
`define EIS_OFF_STATUS 8'h08
`define EIS_OFF_WFLAG 8'h0c
`define EIS_OFF_CLEAR 8'h10
`define EIS_OFF_ENABLE 8'h14
`define EIS_OFF_FUNC 8'h18

// Field positions
`define EIS_IRQ_A_EDGE_POS 0
`define EIS_IRQ_B_EDGE_POS 3
`define EIS_CLR_WAKE_POS 8
`define EIS_EN_WAKE_POS 2

// Fixed read values of reserved bits
`define EIS_IRQ_EDGE_ONES 8'h70
`define EIS_WAKE_EDGE_ONES 8'hc0

// Reset values
`define EIS_RST_EDGE 2'h0
`define EIS_RST_WEDGE 6'h00
`define EIS_RST_EN 3'h0
`define EIS_RST_FUNC 2'h0

`endif

// ===== include/eis_pkg.sv
// Types shared by the edge-select block
`include "eis_consts.svh"
package eis_pkg;

  // APB request from master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`EIS_AW-1:0] paddr;
    logic [31:0] pwdata;
  } eis_apb_req_t;

  // APB answer to master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } eis_apb_rsp_t;

  // Register state of the top module
  typedef struct packed {
    logic [1:0] irq_edge;
    logic [`EIS_NWAKE-1:0] wake_edge;
    logic [2:0] en;
    logic [1:0] func;
    logic irq;
    logic err;
    logic [31:0] rdata;
  } eis_regs_t;

endpackage : eis_pkg

// ===== rtl/eis_edge_det.sv
// Pin synchroniser and selectable edge detector
`timescale 1ns/10ps
`include "eis_consts.svh"
module eis_edge_det
  import eis_pkg::*;
#(
  parameter int N = `EIS_NPINS
)(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins and edge choice
  input wire logic [N-1:0] pins,
  input wire logic [N-1:0] rise_sel,
  // One-cycle edge pulses
  output logic [N-1:0] pulse
);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] prev;
  } eis_det_t;

  eis_det_t r, r_nxt;

  // Pick rising or falling edge
  function automatic logic eis_pick(input logic sel, input logic now, input logic old);
    eis_pick = sel ? (now & ~old) : (~now & old);
  endfunction : eis_pick

  // Two-stage sync then one history stage
  always_comb
  begin
    r_nxt = r;
    r_nxt.s1 = pins;
    r_nxt.s2 = r.s1;
    r_nxt.prev = r.s2;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= r_nxt;
  end

  // Per-pin edge selection
  for (genvar i = 0; i < N; i++)
  begin : g_pin
    assign pulse[i] = eis_pick(rise_sel[i], r.s2[i], r.prev[i]);
  end

  property p_one_cycle;
    @(posedge pclk) disable iff (!presetn)
      (pulse & $past(pulse) & ~(rise_sel ^ $past(rise_sel))) == '0;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("edge pulse lasted two cycles");

endmodule : eis_edge_det

// ===== rtl/eis_sticky.sv
// Sticky request flags, set wins over clear
`timescale 1ns/10ps
`include "eis_consts.svh"
module eis_sticky
  import eis_pkg::*;
#(
  parameter int N = `EIS_NPINS
)(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Set and clear strobes
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] clr,
  // Flag levels
  output logic [N-1:0] flags
);

  typedef struct packed {
    logic [N-1:0] f;
  } eis_stk_t;

  eis_stk_t r, r_nxt;

  // Clear first, then set, so a set in the same cycle survives
  always_comb
  begin
    r_nxt = r;
    r_nxt.f = (r.f & ~clr) | set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= r_nxt;
  end

  assign flags = r.f;

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
      |set |=> (flags & $past(set)) == $past(set);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("set flag lost");

endmodule : eis_sticky

// ===== rtl/eis_edge_ctrl.sv
// External interrupt edge-select controller with APB registers
`timescale 1ns/10ps
`include "eis_consts.svh"
module eis_edge_ctrl
  import eis_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire eis_apb_req_t apb_req,
  output eis_apb_rsp_t apb_rsp,
  // Interrupt pins
  input wire logic irq_pin_a,
  input wire logic irq_pin_b,
  // Wakeup pins, bit 5 doubles as conversion trigger
  input wire logic [`EIS_NWAKE-1:0] wake_pins,
  // Outputs
  output logic irq,
  output logic conversion_trigger
);

  eis_regs_t r, r_nxt;

  // Edge pulses and sticky flags
  logic [`EIS_NPINS-1:0] pins;
  logic [`EIS_NPINS-1:0] rise_sel;
  logic [`EIS_NPINS-1:0] pulse;
  logic [`EIS_NPINS-1:0] set;
  logic [`EIS_NPINS-1:0] clr;
  logic [`EIS_NPINS-1:0] flags;

  // Bus phase decode
  logic setup;
  logic access;
  logic wr;

  // Address is one of ours
  function automatic logic eis_mapped(input logic [`EIS_AW-1:0] a);
    case (a)
      `EIS_OFF_IRQ_EDGE,
      `EIS_OFF_WAKE_EDGE,
      `EIS_OFF_STATUS,
      `EIS_OFF_WFLAG,
      `EIS_OFF_CLEAR,
      `EIS_OFF_ENABLE,
      `EIS_OFF_FUNC:
        eis_mapped = 1'b1;
      default:
        eis_mapped = 1'b0;
    endcase
  endfunction : eis_mapped

  // Read value of a register
  function automatic logic [31:0] eis_read(
    input logic [`EIS_AW-1:0] a,
    input eis_regs_t s,
    input logic [`EIS_NPINS-1:0] f
  );
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `EIS_OFF_IRQ_EDGE:
      begin
        v = `EIS_IRQ_EDGE_ONES;
        v[`EIS_IRQ_A_EDGE_POS] = s.irq_edge[0];
        v[`EIS_IRQ_B_EDGE_POS] = s.irq_edge[1];
      end
      `EIS_OFF_WAKE_EDGE:
        v = `EIS_WAKE_EDGE_ONES | {2'h0, s.wake_edge};
      `EIS_OFF_STATUS:
        v = {6'h00, f[1:0]};
      `EIS_OFF_WFLAG:
        v = {2'h0, f[`EIS_NPINS-1:2]};
      `EIS_OFF_ENABLE:
        v = {5'h00, s.en};
      `EIS_OFF_FUNC:
        v = {6'h00, s.func};
      default:
        v = 8'h00;
    endcase
    eis_read = {24'h000000, v};
  endfunction : eis_read

  // Phase strobes
  assign setup = apb_req.psel & ~apb_req.penable;
  assign access = apb_req.psel & apb_req.penable;
  assign wr = access & apb_req.pwrite;

  // Pin vector: irq a, irq b, then wake pins
  assign pins = {wake_pins, irq_pin_b, irq_pin_a};
  assign rise_sel = {r.wake_edge, r.irq_edge};

  eis_edge_det #(
    .N(`EIS_NPINS)
  ) u_det (
    .pclk(pclk),
    .presetn(presetn),
    .pins(pins),
    .rise_sel(rise_sel),
    .pulse(pulse)
  );

  // Irq pins raise flags only in interrupt function
  assign set[1:0] = pulse[1:0] & r.func;
  assign set[`EIS_NPINS-1:2] = pulse[`EIS_NPINS-1:2];

  // Write-one-to-clear strobes
  always_comb
  begin
    clr = '0;
    if (wr && apb_req.paddr == `EIS_OFF_CLEAR)
    begin
      clr[1:0] = apb_req.pwdata[1:0];
      clr[`EIS_NPINS-1:2] = apb_req.pwdata[`EIS_CLR_WAKE_POS +: `EIS_NWAKE];
    end
  end

  eis_sticky #(
    .N(`EIS_NPINS)
  ) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set(set),
    .clr(clr),
    .flags(flags)
  );

  // Register updates, read capture and interrupt level
  always_comb
  begin
    r_nxt = r;
    // Read data captured in setup, presented in access
    if (setup)
    begin
      r_nxt.rdata = eis_read(apb_req.paddr, r, flags);
      r_nxt.err = ~eis_mapped(apb_req.paddr);
    end
    // Writes land at the access edge
    if (wr)
    begin
      case (apb_req.paddr)
        `EIS_OFF_IRQ_EDGE:
        begin
          r_nxt.irq_edge[0] = apb_req.pwdata[`EIS_IRQ_A_EDGE_POS];
          r_nxt.irq_edge[1] = apb_req.pwdata[`EIS_IRQ_B_EDGE_POS];
        end
        `EIS_OFF_WAKE_EDGE:
          r_nxt.wake_edge = apb_req.pwdata[`EIS_NWAKE-1:0];
        `EIS_OFF_ENABLE:
          r_nxt.en = apb_req.pwdata[2:0];
        `EIS_OFF_FUNC:
          r_nxt.func = apb_req.pwdata[1:0];
        default:
          r_nxt.func = r.func;
      endcase
    end
    // Common wake enable, own enables for the irq pins
    r_nxt.irq = |(flags[1:0] & r.en[1:0])
      | (r.en[`EIS_EN_WAKE_POS] & (|flags[`EIS_NPINS-1:2]));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.irq_edge <= `EIS_RST_EDGE;
      r.wake_edge <= `EIS_RST_WEDGE;
      r.en <= `EIS_RST_EN;
      r.func <= `EIS_RST_FUNC;
    end
    else
      r <= r_nxt;
  end

  // Bus answer: zero wait state
  assign apb_rsp.prdata = r.rdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = access & r.err;

  // Interrupt and trigger outputs
  assign irq = r.irq;
  assign conversion_trigger = pulse[`EIS_NPINS-1];

  // Rising irq b sets its flag when rising is chosen
  property p_irqb_rise;
    @(posedge pclk) disable iff (!presetn)
      ($rose(irq_pin_b) && r.irq_edge[1] && r.func[1])
        ##1 (r.irq_edge[1] && r.func[1])[*2] |=> flags[1];
  endproperty
  a_irqb_rise: assert property (p_irqb_rise)
    else $error("irq b rising edge missed");

  property p_irqa_fall;
    @(posedge pclk) disable iff (!presetn)
      ($fell(irq_pin_a) && !r.irq_edge[0] && r.func[0])
        ##1 (!r.irq_edge[0] && r.func[0])[*2] |=> flags[0];
  endproperty
  a_irqa_fall: assert property (p_irqa_fall)
    else $error("irq a falling edge missed");

  property p_trig_rise;
    @(posedge pclk) disable iff (!presetn)
      ($rose(wake_pins[5]) && r.wake_edge[5]) ##1 r.wake_edge[5]
        |-> ##1 conversion_trigger;
  endproperty
  a_trig_rise: assert property (p_trig_rise)
    else $error("trigger pulse missing two cycles after rise");

  property p_wake0_fall;
    @(posedge pclk) disable iff (!presetn)
      ($fell(wake_pins[0]) && !r.wake_edge[0]) ##1 (!r.wake_edge[0])[*2]
        |=> flags[2];
  endproperty
  a_wake0_fall: assert property (p_wake0_fall)
    else $error("wake 0 falling edge missed");

  property p_irq_edge_read;
    @(posedge pclk) disable iff (!presetn)
      (setup && !apb_req.pwrite && apb_req.paddr == `EIS_OFF_IRQ_EDGE)
        |=> apb_rsp.prdata[7:4] == 4'h7 && apb_rsp.prdata[2:1] == 2'h0;
  endproperty
  a_irq_edge_read: assert property (p_irq_edge_read)
    else $error("irq edge reserved bits read wrong");

  property p_wake_edge_read;
    @(posedge pclk) disable iff (!presetn)
      (setup && !apb_req.pwrite && apb_req.paddr == `EIS_OFF_WAKE_EDGE)
        |=> apb_rsp.prdata[7:6] == 2'h3 && apb_rsp.prdata[5:0] == $past(r.wake_edge);
  endproperty
  a_wake_edge_read: assert property (p_wake_edge_read)
    else $error("wake edge register read wrong");

  property p_no_func;
    @(posedge pclk) disable iff (!presetn)
      (!r.func[1] && !flags[1]) |=> !flags[1];
  endproperty
  a_no_func: assert property (p_no_func)
    else $error("irq b flag set without interrupt function");

  property p_wake_common;
    @(posedge pclk) disable iff (!presetn)
      (r.en[`EIS_EN_WAKE_POS] && (|flags[`EIS_NPINS-1:2])) |=> irq;
  endproperty
  a_wake_common: assert property (p_wake_common)
    else $error("common wake enable did not raise irq");

  property p_masked;
    @(posedge pclk) disable iff (!presetn)
      (r.en == 3'h0) |=> !irq;
  endproperty
  a_masked: assert property (p_masked)
    else $error("irq raised with all enables off");

  // Rising irq a sets its flag when rising is chosen
  property p_irqa_rise;
    @(posedge pclk) disable iff (!presetn)
      ($rose(irq_pin_a) && r.irq_edge[0] && r.func[0])
        ##1 (r.irq_edge[0] && r.func[0])[*2] |=> flags[0];
  endproperty
  a_irqa_rise: assert property (p_irqa_rise)
    else $error("irq a rising edge missed");

  // Falling irq b sets its flag when falling is chosen
  property p_irqb_fall;
    @(posedge pclk) disable iff (!presetn)
      ($fell(irq_pin_b) && !r.irq_edge[1] && r.func[1])
        ##1 (!r.irq_edge[1] && r.func[1])[*2] |=> flags[1];
  endproperty
  a_irqb_fall: assert property (p_irqb_fall)
    else $error("irq b falling edge missed");

  // Trigger pulse follows a chosen falling edge
  property p_trig_fall;
    @(posedge pclk) disable iff (!presetn)
      ($fell(wake_pins[5]) && !r.wake_edge[5]) ##1 (!r.wake_edge[5])[*2]
        |-> conversion_trigger;
  endproperty
  a_trig_fall: assert property (p_trig_fall)
    else $error("trigger pulse missing after fall");

  // Rising wake 4 sets its flag when rising is chosen
  property p_wake4_rise;
    @(posedge pclk) disable iff (!presetn)
      ($rose(wake_pins[4]) && r.wake_edge[4]) ##1 (r.wake_edge[4])[*2]
        |=> flags[6];
  endproperty
  a_wake4_rise: assert property (p_wake4_rise)
    else $error("wake 4 rising edge missed");

  // Wake edge bits take the written value
  property p_wake_edge_wr;
    @(posedge pclk) disable iff (!presetn)
      (wr && apb_req.paddr == `EIS_OFF_WAKE_EDGE)
        |=> r.wake_edge == $past(apb_req.pwdata[`EIS_NWAKE-1:0]);
  endproperty
  a_wake_edge_wr: assert property (p_wake_edge_wr)
    else $error("wake edge write lost");

  // Only the two edge bits of the irq register are stored
  property p_irq_edge_wr;
    @(posedge pclk) disable iff (!presetn)
      (wr && apb_req.paddr == `EIS_OFF_IRQ_EDGE)
        |=> r.irq_edge == {$past(apb_req.pwdata[`EIS_IRQ_B_EDGE_POS]),
          $past(apb_req.pwdata[`EIS_IRQ_A_EDGE_POS])};
  endproperty
  a_irq_edge_wr: assert property (p_irq_edge_wr)
    else $error("irq edge write stored wrong bits");

  // Error answer only for unmapped addresses
  property p_slverr;
    @(posedge pclk) disable iff (!presetn)
      (setup ##1 access) |-> apb_rsp.pslverr == !eis_mapped($past(apb_req.paddr));
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("slave error answer wrong");

endmodule : eis_edge_ctrl

// ===== testbench/eis_pin_drv.sv
// Far-side pin driver model for the edge-select block
`timescale 1ns/10ps
module eis_pin_drv
  import eis_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Pins toward the block
  output logic irq_pin_a,
  output logic irq_pin_b,
  output logic [5:0] wake_pins
);
  // Pins idle high, as with pull-ups
  initial {wake_pins, irq_pin_b, irq_pin_a} = 8'hff;

  // Move pins right after an edge, promptly or after a lag
  task set_pins(input logic [7:0] v, input int lag);
    repeat (lag + 1) @(posedge pclk);
    {wake_pins, irq_pin_b, irq_pin_a} <= v;
  endtask : set_pins
endmodule : eis_pin_drv

// ===== testbench/external_irq_edge_select_test.sv
// Self-checking bench for the external interrupt edge-select block
`timescale 1ns/10ps
module external_irq_edge_select_test
  import eis_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  eis_apb_req_t apb_req = '0;
  eis_apb_rsp_t apb_rsp;
  logic irq_pin_a;
  logic irq_pin_b;
  logic [5:0] wake_pins;
  logic irq;
  logic conversion_trigger;
  logic [31:0] q;
  logic [31:0] d;
  logic e;
  int errors = 0;
  int total_checks = 0;
  int trig_n = 0;

  // Clock at 40 MHz
  always #12.5 pclk = ~pclk;

  // Count cycles with the trigger high
  always @(posedge pclk)
    if (conversion_trigger === 1'b1) trig_n <= trig_n + 1;

  eis_edge_ctrl dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .irq_pin_a(irq_pin_a), .irq_pin_b(irq_pin_b), .wake_pins(wake_pins), .irq(irq),
    .conversion_trigger(conversion_trigger));
  eis_pin_drv pins (.pclk(pclk), .irq_pin_a(irq_pin_a), .irq_pin_b(irq_pin_b),
    .wake_pins(wake_pins));

  // Compare and report
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One APB transfer, waits for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    // Wait ends once pready is seen high
    do
    begin
      @(posedge pclk);
    end
    while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(q, exp, what);
  endtask : rd

  function automatic logic [31:0] irq_edge_exp(input logic [31:0] v);
    return {24'h0, 8'h70 | (v[7:0] & 8'h09)};
  endfunction : irq_edge_exp

  function automatic logic [31:0] wake_edge_exp(input logic [31:0] v);
    return {24'h0, 8'hc0 | (v[7:0] & 8'h3f)};
  endfunction : wake_edge_exp

  task done_test(input string name);
    $display("test %s done", name);
  endtask : done_test

  // Pin i: unselected edge gives nothing, selected edge one flag, plus one trigger pulse for pin 7 only
  task edge_case(input int i, input logic r);
    logic [7:0] v;
    int t0;
    v = 8'hff;
    apb(1'b1, 8'h00, (i < 2) ? 32'(r) << (3 * i) : 32'h0);
    apb(1'b1, 8'h04, (i >= 2) ? 32'(r) << (i - 2) : 32'h0);
    v[i] = r;
    pins.set_pins(v, $urandom_range(3));
    repeat (5) @(posedge pclk);
    apb(1'b1, 8'h10, 32'h3f03);
    t0 = trig_n;
    v[i] = ~r;
    pins.set_pins(v, $urandom_range(3));
    repeat (6) @(posedge pclk);
    rd(8'h08, 32'h0, "no flag a/b");
    rd(8'h0c, 32'h0, "no wake flag");
    v[i] = r;
    pins.set_pins(v, $urandom_range(3));
    repeat (6) @(posedge pclk);
    rd(8'h08, (i < 2) ? 32'h1 << i : 32'h0, "flag a/b");
    rd(8'h0c, (i >= 2) ? 32'h1 << (i - 2) : 32'h0, "wake flag");
    chk(32'(trig_n - t0), (i == 7) ? 32'h1 : 32'h0, "trigger pulses");
    chk(32'(irq), 32'h1, "irq raised");
  endtask : edge_case

  // Verdict and end of run
  task test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    test_done;
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'h3a24));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h70, "irq edge reset");
    chk(32'(e), 32'h0, "mapped no error");
    rd(8'h04, 32'hc0, "wake edge reset");
    chk(32'(irq), 32'h0, "irq at reset");
    done_test("reset");
    for (int k = 0; k < 10; k++)
    begin
      d = (k == 0) ? 32'hffffffff : (k == 1) ? 32'h0 : $urandom;
      apb(1'b1, 8'h00, d);
      rd(8'h00, irq_edge_exp(d), "irq edge rw");
      apb(1'b1, 8'h04, d);
      rd(8'h04, wake_edge_exp(d), "wake edge rw");
    end
    apb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0, "unmapped data");
    chk(32'(e), 32'h1, "unmapped error");
    done_test("registers");
    apb(1'b1, 8'h18, 32'h3);
    apb(1'b1, 8'h14, 32'h7);
    rd(8'h14, 32'h7, "enable rw");
    rd(8'h18, 32'h3, "function rw");
    rd(8'h10, 32'h0, "clear reads zero");
    for (int i = 0; i < 8; i++)
      for (int r = 0; r < 2; r++)
        edge_case(i, r[0]);
    done_test("edges");
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h0);
    pins.set_pins(8'hff, 0);
    repeat (5) @(posedge pclk);
    apb(1'b1, 8'h10, 32'h3f03);
    apb(1'b1, 8'h18, 32'h0);
    pins.set_pins(8'hfe, 0);
    repeat (6) @(posedge pclk);
    rd(8'h08, 32'h0, "function off");
    apb(1'b1, 8'h18, 32'h3);
    pins.set_pins(8'hff, 0);
    pins.set_pins(8'hfe, 2);
    repeat (6) @(posedge pclk);
    rd(8'h08, 32'h1, "function on");
    apb(1'b1, 8'h14, 32'h0);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0, "irq masked");
    apb(1'b1, 8'h10, 32'h1);
    pins.set_pins(8'hfa, 0);
    repeat (6) @(posedge pclk);
    rd(8'h0c, 32'h1, "wake flag set");
    apb(1'b1, 8'h14, 32'h3);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0, "wake gated off");
    apb(1'b1, 8'h14, 32'h4);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1, "wake common enable");
    apb(1'b1, 8'h10, 32'h3f03);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0, "irq cleared");
    done_test("gating");
    test_done;
  end
endmodule : external_irq_edge_select_test
